// [aicnd_pkg.sv]
// constants, register map and field layout of the analogue input conditioner
// assumes a 100 MHz core clock and a word-aligned byte-addressed register port
package aicnd_pkg;
  // data scale: 100 % of signal is FULL_SCALE, signed 16-bit samples
  localparam int DW = 16;
  localparam int FS_SHIFT = 13;
  localparam logic signed [31:0] FULL_SCALE = 32'sh0000_2000;
  localparam logic signed [31:0] LIVE_ZERO = 32'sh0000_0666;
  localparam logic signed [15:0] SPAN_LIMIT = 16'sh3333;
  // span selection codes
  localparam logic [1:0] SPAN_FULL = 2'h0;
  localparam logic [1:0] SPAN_LIVE = 2'h1;
  localparam logic [1:0] SPAN_BIP = 2'h2;
  localparam logic [1:0] SPAN_CUSTOM = 2'h3;
  // register offsets
  localparam logic [7:0] REG_CH_CFG = 8'h00;
  localparam logic [7:0] REG_CH_LOW = 8'h04;
  localparam logic [7:0] REG_CH_HIGH = 8'h08;
  localparam logic [7:0] REG_CH_OUT = 8'h0C;
  localparam logic [7:0] REG_DEADBAND = 8'h40;
  localparam logic [7:0] REG_IDLE_THR = 8'h44;
  localparam logic [7:0] REG_IDLE_HOLD = 8'h48;
  localparam logic [7:0] REG_TRIM = 8'h4C;
  localparam logic [7:0] REG_REF_LOW = 8'h60;
  localparam logic [7:0] REG_REF_HIGH = 8'h64;
  localparam logic [7:0] REG_STATUS = 8'h68;
  localparam logic [7:0] REG_MON3 = 8'h70;
  localparam logic [7:0] REG_MON4 = 8'h74;
  // channel configuration fields
  localparam int CFG_SPAN_LSB = 0;
  localparam int CFG_ORDER2_BIT = 2;
  localparam int CFG_FBSRC_BIT = 3;
  localparam int CFG_FLIP_BIT = 4;
  localparam int CFG_REFSC_BIT = 5;
  localparam int CFG_SHIFT_LSB = 8;
  localparam int CFG_W = 12;
  // trim command bits
  localparam int TRIM_CAPTURE_BIT = 0;
  localparam int TRIM_CLEAR_BIT = 1;
  // reset values
  localparam logic [11:0] CFG_RST = 12'h000;
  localparam logic [15:0] REF_HIGH_RST = 16'h2000;
  localparam logic [15:0] SPAN_HIGH_RST = 16'h2000;
  // idle timer: one count per millisecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_TICK_NS = 1000000;
  localparam int IDLE_TICK_CYCLES = IDLE_TICK_NS / CLK_PERIOD_NS;
  // register selector
  typedef enum logic [3:0] {
    SEL_NONE, SEL_CFG, SEL_LOW, SEL_HIGH, SEL_OUT, SEL_DEAD, SEL_THR,
    SEL_HOLD, SEL_TRIM, SEL_REFL, SEL_REFH, SEL_STAT, SEL_MON
  } aicnd_sel_e;
endpackage

// [aicnd_chan.sv]
// one conditioning channel: trim, smoothing, span, reference scale, dead zone
// assumes samples arrive as one-cycle strobes synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module aicnd_chan (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic smp_valid,
  input wire logic signed [15:0] smp,
  input wire logic signed [15:0] trim,
  input wire logic [1:0] span,
  input wire logic signed [15:0] span_low,
  input wire logic signed [15:0] span_high,
  input wire logic [3:0] shift,
  input wire logic order2,
  input wire logic ref_en,
  input wire logic signed [15:0] ref_low,
  input wire logic signed [15:0] ref_high,
  input wire logic signed [15:0] deadband,
  input wire logic flip,
  output logic signed [15:0] out_value,
  output logic out_valid
);
  logic signed [31:0] f1_q, f1_d, f2_q, f2_d, x, filt, s, r, d;
  logic signed [31:0] den, dz;
  logic v1_q, v1_d;
  logic signed [15:0] out_d;

  // smoothing stages; shift zero passes the sample straight through
  always_comb begin
    x = 32'(smp) - 32'(trim);
    f1_d = f1_q;
    f2_d = f2_q;
    v1_d = smp_valid;
    if (smp_valid) begin
      f1_d = (shift == 4'h0) ? x : f1_q + ((x - f1_q) >>> shift);
      f2_d = (shift == 4'h0) ? f1_d : f2_q + ((f1_d - f2_q) >>> shift);
    end
  end

  // span mapping, reference scaling, dead zone and inversion
  always_comb begin
    filt = order2 ? f2_q : f1_q;
    den = 32'(span_high) - 32'(span_low);
    case (span)
      aicnd_pkg::SPAN_FULL: s = filt;
      aicnd_pkg::SPAN_LIVE: s = ((filt - aicnd_pkg::LIVE_ZERO) * 5) >>> 2;
      aicnd_pkg::SPAN_BIP: s = filt;
      default: begin
        s = (den == 0) ? 32'sh0 :
          ((filt - 32'(span_low)) * aicnd_pkg::FULL_SCALE) / den;
      end
    endcase
    if (s > aicnd_pkg::FULL_SCALE) s = aicnd_pkg::FULL_SCALE;
    if (span == aicnd_pkg::SPAN_BIP) begin
      if (s < -aicnd_pkg::FULL_SCALE) s = -aicnd_pkg::FULL_SCALE;
    end else if (s < 0) begin
      s = 32'sh0;
    end
    r = ref_en ? 32'(ref_low) + ((s * (32'(ref_high) - 32'(ref_low)))
      >>> aicnd_pkg::FS_SHIFT) : s;
    dz = 32'(deadband);
    d = (dz != 0 && r <= dz && r >= -dz) ? 32'sh0 : r;
    if (flip) d = aicnd_pkg::FULL_SCALE - d;
    out_d = v1_q ? d[15:0] : out_value;
  end

  // register filter state and result
  always_ff @(posedge core_clk) begin
    if (reset) begin
      f1_q <= 32'sh0;
      f2_q <= 32'sh0;
      v1_q <= 1'b0;
      out_value <= 16'sh0;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      f1_q <= f1_d;
      f2_q <= f2_d;
      v1_q <= v1_d;
      out_value <= out_d;
      out_valid <= v1_q;
    end
  end

  chk_filter_bypass: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && smp_valid && shift == 4'h0 |=> f1_q == $past(x))
    else $error("zero smoothing time did not pass the sample");
  chk_dead_zone: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && v1_q && !flip && deadband > 0 && r <= 32'(deadband)
      && r >= -32'(deadband) |=> out_value == 16'sh0)
    else $error("value inside dead zone not forced to zero");
  chk_live_zero: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && v1_q && span == aicnd_pkg::SPAN_LIVE && !ref_en && !flip
      && filt <= aicnd_pkg::LIVE_ZERO |=> out_value == 16'sh0)
    else $error("live zero span gave nonzero output below 20 percent");
  chk_flip_zero: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && v1_q && flip && r == 32'sh0
      |=> out_value == aicnd_pkg::FULL_SCALE[15:0])
    else $error("inverted zero did not give full scale");
  cov_flipped: cover property (@(posedge core_clk) clk_en && v1_q && flip);
endmodule
`default_nettype wire

// [aicnd_top.sv]
// analogue input conditioner: four channels, register port, idle stop logic
// assumes synchronous samples, fieldbus values written through the port
`timescale 1ns/1ps
`default_nettype none
module aicnd_top #(
  parameter int TICK_CYCLES = aicnd_pkg::IDLE_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic adc_valid,
  input wire logic [3:0][15:0] adc_sample,
  output logic [3:0][15:0] ch_value,
  output logic [3:0] ch_valid,
  output logic [1:0] idle_stop
);
  // refuse a tick period that the idle timer cannot count
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // decode an address into a register kind, shared by read and write
  function automatic aicnd_pkg::aicnd_sel_e reg_sel(input logic [7:0] a);
    reg_sel = aicnd_pkg::SEL_NONE;
    if (a[7:6] == 2'b00) begin
      case (a[3:0])
        aicnd_pkg::REG_CH_CFG[3:0]: reg_sel = aicnd_pkg::SEL_CFG;
        aicnd_pkg::REG_CH_LOW[3:0]: reg_sel = aicnd_pkg::SEL_LOW;
        aicnd_pkg::REG_CH_HIGH[3:0]: reg_sel = aicnd_pkg::SEL_HIGH;
        aicnd_pkg::REG_CH_OUT[3:0]: reg_sel = aicnd_pkg::SEL_OUT;
        default: reg_sel = aicnd_pkg::SEL_NONE;
      endcase
    end else if (a[7:5] == aicnd_pkg::REG_DEADBAND[7:5]) begin
      case (a[3:0])
        aicnd_pkg::REG_DEADBAND[3:0]: reg_sel = aicnd_pkg::SEL_DEAD;
        aicnd_pkg::REG_IDLE_THR[3:0]: reg_sel = aicnd_pkg::SEL_THR;
        aicnd_pkg::REG_IDLE_HOLD[3:0]: reg_sel = aicnd_pkg::SEL_HOLD;
        aicnd_pkg::REG_TRIM[3:0]: reg_sel = aicnd_pkg::SEL_TRIM;
        default: reg_sel = aicnd_pkg::SEL_NONE;
      endcase
    end else begin
      case (a)
        aicnd_pkg::REG_REF_LOW: reg_sel = aicnd_pkg::SEL_REFL;
        aicnd_pkg::REG_REF_HIGH: reg_sel = aicnd_pkg::SEL_REFH;
        aicnd_pkg::REG_STATUS: reg_sel = aicnd_pkg::SEL_STAT;
        aicnd_pkg::REG_MON3: reg_sel = aicnd_pkg::SEL_MON;
        aicnd_pkg::REG_MON4: reg_sel = aicnd_pkg::SEL_MON;
        default: reg_sel = aicnd_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // clamp a custom span point into the accepted window
  function automatic logic [15:0] span_clip(input logic [15:0] v);
    if ($signed(v) > aicnd_pkg::SPAN_LIMIT) span_clip = aicnd_pkg::SPAN_LIMIT;
    else if ($signed(v) < -aicnd_pkg::SPAN_LIMIT)
      span_clip = 16'(-aicnd_pkg::SPAN_LIMIT);
    else span_clip = v;
  endfunction

  logic [11:0] cfg_q [4];
  logic [11:0] cfg_d [4];
  logic [15:0] low_q [4];
  logic [15:0] low_d [4];
  logic [15:0] high_q [4];
  logic [15:0] high_d [4];
  logic [15:0] dead_q [2];
  logic [15:0] dead_d [2];
  logic [15:0] thr_q [2];
  logic [15:0] thr_d [2];
  logic [15:0] hold_q [2];
  logic [15:0] hold_d [2];
  logic [15:0] trim_q [2];
  logic [15:0] trim_d [2];
  logic [15:0] mon_q [2];
  logic [15:0] mon_d [2];
  logic [15:0] ref_low_q, ref_low_d, ref_high_q, ref_high_d;
  logic [31:0] rd_data_d;
  aicnd_pkg::aicnd_sel_e sel;
  logic [1:0] ci;

  // register writes and read data, answered one cycle after the strobe
  always_comb begin
    sel = reg_sel(addr);
    ci = addr[5:4];
    cfg_d = cfg_q;
    low_d = low_q;
    high_d = high_q;
    dead_d = dead_q;
    thr_d = thr_q;
    hold_d = hold_q;
    trim_d = trim_q;
    mon_d = mon_q;
    ref_low_d = ref_low_q;
    ref_high_d = ref_high_q;
    rd_data_d = 32'h0000_0000;
    if (wr_en) begin
      case (sel)
        aicnd_pkg::SEL_CFG: cfg_d[ci] = wdata[11:0];
        aicnd_pkg::SEL_LOW: low_d[ci] = span_clip(wdata[15:0]);
        aicnd_pkg::SEL_HIGH: high_d[ci] = span_clip(wdata[15:0]);
        aicnd_pkg::SEL_DEAD: dead_d[ci[0]] = wdata[15:0];
        aicnd_pkg::SEL_THR: thr_d[ci[0]] = wdata[15:0];
        aicnd_pkg::SEL_HOLD: hold_d[ci[0]] = wdata[15:0];
        aicnd_pkg::SEL_TRIM: begin
          if (wdata[aicnd_pkg::TRIM_CLEAR_BIT])
            trim_d[ci[0]] = 16'h0000;
          else if (wdata[aicnd_pkg::TRIM_CAPTURE_BIT])
            trim_d[ci[0]] = adc_sample[ci[0]];
        end
        aicnd_pkg::SEL_REFL: ref_low_d = wdata[15:0];
        aicnd_pkg::SEL_REFH: ref_high_d = wdata[15:0];
        aicnd_pkg::SEL_MON: mon_d[addr[2]] = wdata[15:0];
        default: ;
      endcase
    end
    if (rd_en) begin
      case (sel)
        aicnd_pkg::SEL_CFG: rd_data_d = {20'h00000, cfg_q[ci]};
        aicnd_pkg::SEL_LOW: rd_data_d = {16'h0000, low_q[ci]};
        aicnd_pkg::SEL_HIGH: rd_data_d = {16'h0000, high_q[ci]};
        aicnd_pkg::SEL_OUT: rd_data_d = {16'h0000, ch_value[ci]};
        aicnd_pkg::SEL_DEAD: rd_data_d = {16'h0000, dead_q[ci[0]]};
        aicnd_pkg::SEL_THR: rd_data_d = {16'h0000, thr_q[ci[0]]};
        aicnd_pkg::SEL_HOLD: rd_data_d = {16'h0000, hold_q[ci[0]]};
        aicnd_pkg::SEL_TRIM: rd_data_d = {16'h0000, trim_q[ci[0]]};
        aicnd_pkg::SEL_REFL: rd_data_d = {16'h0000, ref_low_q};
        aicnd_pkg::SEL_REFH: rd_data_d = {16'h0000, ref_high_q};
        aicnd_pkg::SEL_STAT: rd_data_d = {30'h0000_0000, idle_stop};
        aicnd_pkg::SEL_MON: rd_data_d = {16'h0000, mon_q[addr[2]]};
        default: rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  // register bank and read answer; clk_en low freezes every setting
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        cfg_q[i] <= aicnd_pkg::CFG_RST;
        low_q[i] <= 16'h0000;
        high_q[i] <= aicnd_pkg::SPAN_HIGH_RST;
      end
      for (int j = 0; j < 2; j++) begin
        dead_q[j] <= 16'h0000;
        thr_q[j] <= 16'h0000;
        hold_q[j] <= 16'h0000;
        trim_q[j] <= 16'h0000;
        mon_q[j] <= 16'h0000;
      end
      ref_low_q <= 16'h0000;
      ref_high_q <= aicnd_pkg::REF_HIGH_RST;
      rd_data <= 32'h0000_0000;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      low_q <= low_d;
      high_q <= high_d;
      dead_q <= dead_d;
      thr_q <= thr_d;
      hold_q <= hold_d;
      trim_q <= trim_d;
      mon_q <= mon_d;
      ref_low_q <= ref_low_d;
      ref_high_q <= ref_high_d;
      rd_data <= rd_data_d;
    end
  end

  // four channel pipelines; 3 and 4 may take fieldbus data and invert
  for (genvar c = 0; c < 4; c++) begin : g_ch
    localparam bit LOW_PAIR = (c < 2);
    logic [15:0] smp_sel;
    assign smp_sel = (!LOW_PAIR && cfg_q[c][aicnd_pkg::CFG_FBSRC_BIT]) ?
      mon_q[c % 2] : adc_sample[c];
    aicnd_chan u_chan (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .smp_valid(adc_valid),
      .smp(smp_sel),
      .trim(LOW_PAIR ? trim_q[c % 2] : 16'h0000),
      .span(cfg_q[c][aicnd_pkg::CFG_SPAN_LSB +: 2]),
      .span_low(low_q[c]),
      .span_high(high_q[c]),
      .shift(cfg_q[c][aicnd_pkg::CFG_SHIFT_LSB +: 4]),
      .order2(LOW_PAIR & cfg_q[c][aicnd_pkg::CFG_ORDER2_BIT]),
      .ref_en(cfg_q[c][aicnd_pkg::CFG_REFSC_BIT]),
      .ref_low(ref_low_q),
      .ref_high(ref_high_q),
      .deadband(LOW_PAIR ? dead_q[c % 2] : 16'h0000),
      .flip(!LOW_PAIR & cfg_q[c][aicnd_pkg::CFG_FLIP_BIT]),
      .out_value(ch_value[c]),
      .out_valid(ch_valid[c])
    );
  end

  // idle detection on channels 1 and 2 with a millisecond hold timer
  logic [31:0] tick_q, tick_d;
  logic tick;
  logic [15:0] cnt_q [2];
  logic [15:0] cnt_d [2];
  logic [1:0] idle_d, below;
  logic signed [15:0] lvl [2];
  logic signed [15:0] mag [2];

  // hold timer; any cycle at or above threshold clears the count
  always_comb begin
    tick = (tick_q == 32'(TICK_CYCLES - 1));
    tick_d = tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
    for (int j = 0; j < 2; j++) begin
      lvl[j] = ch_value[j];
      mag[j] = (lvl[j] < 0) ? -lvl[j] : lvl[j];
      if (cfg_q[j][aicnd_pkg::CFG_SPAN_LSB +: 2] == aicnd_pkg::SPAN_BIP)
        below[j] = mag[j] < $signed(thr_q[j]);
      else
        below[j] = lvl[j] < $signed(thr_q[j]);
      cnt_d[j] = 16'h0000;
      if (below[j]) begin
        cnt_d[j] = cnt_q[j];
        if (tick && cnt_q[j] < hold_q[j]) cnt_d[j] = cnt_q[j] + 16'h0001;
      end
      idle_d[j] = below[j] && (cnt_d[j] >= hold_q[j]);
    end
  end

  // register tick divider, hold counters and stop flags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_q <= 32'h0000_0000;
      cnt_q[0] <= 16'h0000;
      cnt_q[1] <= 16'h0000;
      idle_stop <= 2'b00;
    end else if (clk_en) begin
      tick_q <= tick_d;
      cnt_q <= cnt_d;
      idle_stop <= idle_d;
    end
  end

  // checks on the idle logic and the trim clear
  chk_idle_cause: assert property (@(posedge core_clk) disable iff (reset)
    $rose(idle_stop[0]) |-> $past(below[0]))
    else $error("idle stop raised without low input");
  chk_idle_hold: assert property (@(posedge core_clk) disable iff (reset)
    idle_stop[0] |-> cnt_q[0] >= hold_q[0])
    else $error("idle stop raised before hold time");
  chk_idle_restart: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && !below[0] |=> !idle_stop[0] && cnt_q[0] == 16'h0000)
    else $error("hold timer not restarted above threshold");
  chk_trim_clear: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_en && sel == aicnd_pkg::SEL_TRIM
      && wdata[aicnd_pkg::TRIM_CLEAR_BIT] |=> trim_q[$past(ci[0])] == 16'h0000)
    else $error("trim clear did not restore zero");

  // checks on the register port
  chk_span_window: assert property (@(posedge core_clk) disable iff (reset)
    $signed(low_q[0]) <= aicnd_pkg::SPAN_LIMIT
      && $signed(low_q[0]) >= -aicnd_pkg::SPAN_LIMIT)
    else $error("custom span point outside accepted window");
  chk_read_status: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && rd_en && sel == aicnd_pkg::SEL_STAT
      |=> rd_data == {30'h0000_0000, $past(idle_stop)})
    else $error("status read did not return idle flags");
  chk_read_quiet: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && !rd_en |=> rd_data == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  chk_mon_write: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_en && addr == aicnd_pkg::REG_MON3
      |=> mon_q[0] == $past(wdata[15:0]))
    else $error("fieldbus value not stored");
  chk_cfg_write: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_en && sel == aicnd_pkg::SEL_CFG
      |=> cfg_q[$past(ci)] == $past(wdata[11:0]))
    else $error("channel configuration not stored");

  // main scenarios
  cov_idle: cover property (@(posedge core_clk) $rose(idle_stop[0]));
  cov_restart: cover property (@(posedge core_clk) disable iff (reset)
    $fell(below[0]) && cnt_q[0] != 16'h0000);
  cov_capture: cover property (@(posedge core_clk) wr_en
    && sel == aicnd_pkg::SEL_TRIM && wdata[aicnd_pkg::TRIM_CAPTURE_BIT]);
endmodule
`default_nettype wire

// [aicnd_front.sv]
// analogue front end model: converts levels and strobes all four out
// assumes the bench gives levels and a one-cycle go request
`timescale 1ns/1ps
`default_nettype none
module aicnd_front (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [3:0][15:0] level,
  output logic adc_valid,
  output logic [3:0][15:0] adc_sample
);
  // conversion register keeps the last result between strobes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      adc_valid <= 1'b0;
      adc_sample <= '0;
    end else begin
      adc_valid <= go;
      if (go) begin
        adc_sample <= level;
      end
    end
  end
endmodule
`default_nettype wire

// [aicnd_bench.sv]
// self-checking bench for the analogue input conditioner
// assumes the front end model and a 4-cycle idle tick
`timescale 1ns/1ps
`default_nettype none
module aicnd_bench;
  logic core_clk, reset, clk_en, wr_en, rd_en, go, adc_valid;
  logic [7:0] addr;
  logic [31:0] wdata, rd_data;
  logic [3:0][15:0] level, adc_sample, ch_value;
  logic [3:0] ch_valid;
  logic [1:0] idle_stop;
  int error_cnt = 0;
  int cmp_count = 0;

  aicnd_top #(.TICK_CYCLES(4)) DUT (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .adc_valid(adc_valid),
    .adc_sample(adc_sample), .ch_value(ch_value), .ch_valid(ch_valid),
    .idle_stop(idle_stop));
  aicnd_front fe (.core_clk(core_clk), .reset(reset), .go(go),
    .level(level), .adc_valid(adc_valid), .adc_sample(adc_sample));

  // clock and time-zero values
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    reset = 1'b1;
    {clk_en, wr_en, rd_en, go} = 4'h8;
    addr = 8'h00;
    wdata = '0;
    level = '0;
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rst();
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // one conversion; returns just after the outputs update
  task automatic conv(input logic [15:0] v0, input logic [15:0] v2);
    int n;
    @(posedge core_clk);
    level[0] <= v0;
    level[2] <= v2;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    n = 0;
    while (ch_valid[0] !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 10) check("ch_valid", 32'h0, 32'h1);
    check("ch_valid all", {28'h0, ch_valid}, 32'hF);
  endtask

  // bounded wait for the channel 1 stop level
  task automatic wait_stop(input logic e);
    int n;
    n = 0;
    while (idle_stop[0] !== e && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("idle_stop", {31'h0, idle_stop[0]}, {31'h0, e});
  endtask

  task automatic t_regs();
    logic [31:0] d;
    rd(aicnd_pkg::REG_REF_HIGH, d);
    check("ref_high", d, 32'h0000_2000);
    rd(aicnd_pkg::REG_CH_HIGH, d);
    check("span_high", d, 32'h0000_2000);
    wr(aicnd_pkg::REG_CH_LOW, 32'h0000_7000);
    rd(aicnd_pkg::REG_CH_LOW, d);
    check("span_low", d, 32'h0000_3333);
    wr(aicnd_pkg::REG_CH_LOW, 32'h0000_A000);
    rd(aicnd_pkg::REG_CH_LOW, d);
    check("span_low", d, 32'h0000_CCCD);
    wr(8'h80, 32'h0000_1234);
    rd(8'h80, d);
    check("unmapped", d, 32'h0);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(aicnd_pkg::REG_REF_LOW, 32'h0000_0100);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(aicnd_pkg::REG_REF_LOW, d);
    check("frozen write", d, 32'h0);
    $display("register test done");
  endtask

  // every span code with filtering bypassed
  task automatic t_span();
    logic [15:0] smp[4] = '{16'h1000, 16'h1000, 16'hF000, 16'h1400};
    logic [15:0] exp[4] = '{16'h1000, 16'h0C00, 16'hF000, 16'h1000};
    rst();
    wr(aicnd_pkg::REG_CH_LOW, 32'h0000_1000);
    wr(aicnd_pkg::REG_CH_HIGH, 32'h0000_1800);
    for (int c = 0; c < 4; c++) begin
      wr(aicnd_pkg::REG_CH_CFG, c);
      conv(smp[c], 16'h0);
      check("span", ch_value[0], exp[c]);
    end
    wr(aicnd_pkg::REG_REF_LOW, 32'h0000_0400);
    wr(aicnd_pkg::REG_REF_HIGH, 32'h0000_1400);
    wr(aicnd_pkg::REG_CH_CFG, 32'h0000_0020);
    conv(16'h1000, 16'h0);
    check("ref scale", ch_value[0], 16'h0C00);
    $display("span test done");
  endtask

  task automatic t_dead();
    rst();
    wr(aicnd_pkg::REG_CH_CFG, 32'h2);
    wr(aicnd_pkg::REG_DEADBAND, 32'h0000_0100);
    conv(16'h0100, 16'h0);
    check("dead pos", ch_value[0], 16'h0);
    conv(16'hFF00, 16'h0);
    check("dead neg", ch_value[0], 16'h0);
    conv(16'h0101, 16'h0);
    check("dead out", ch_value[0], 16'h0101);
    $display("dead zone test done");
  endtask

  task automatic t_trim();
    logic [31:0] d;
    rst();
    conv(16'h0400, 16'h0);
    wr(aicnd_pkg::REG_TRIM, 32'h1);
    rd(aicnd_pkg::REG_TRIM, d);
    check("trim", d, 32'h0000_0400);
    conv(16'h1400, 16'h0);
    check("trimmed", ch_value[0], 16'h1000);
    wr(aicnd_pkg::REG_TRIM, 32'h3);
    rd(aicnd_pkg::REG_TRIM, d);
    check("trim clr", d, 32'h0);
    conv(16'h1400, 16'h0);
    check("untrimmed", ch_value[0], 16'h1400);
    $display("trim test done");
  endtask

  task automatic t_filt();
    rst();
    wr(aicnd_pkg::REG_CH_CFG, 32'h0000_0100);
    wr(8'h20, 32'h0000_0104);
    conv(16'h1000, 16'h1000);
    check("lp1 a", ch_value[0], 16'h0800);
    check("ch3 lp", ch_value[2], 16'h0800);
    conv(16'h1000, 16'h1000);
    check("lp1 b", ch_value[0], 16'h0C00);
    rst();
    wr(aicnd_pkg::REG_CH_CFG, 32'h0000_0104);
    conv(16'h1000, 16'h0);
    check("lp2", {31'h0, $signed(ch_value[0]) < 16'sh0800}, 32'h1);
    $display("filter test done");
  endtask

  task automatic t_fbus();
    rst();
    wr(aicnd_pkg::REG_MON3, 32'h0000_0800);
    wr(8'h20, 32'h8);
    conv(16'h0, 16'h1F00);
    check("fbus", ch_value[2], 16'h0800);
    wr(8'h20, 32'h18);
    wr(aicnd_pkg::REG_MON4, 32'h0000_0400);
    wr(8'h30, 32'h18);
    conv(16'h0, 16'h1F00);
    check("flip", ch_value[2], 16'h1800);
    check("ch4 flip", ch_value[3], 16'h1C00);
    wr(aicnd_pkg::REG_MON3, 32'h0);
    conv(16'h0, 16'h1F00);
    check("flip zero", ch_value[2], 16'h2000);
    $display("fieldbus test done");
  endtask

  task automatic t_idle();
    logic [31:0] d;
    rst();
    wr(aicnd_pkg::REG_IDLE_HOLD, 32'h4);
    conv(16'h1000, 16'h0);
    wr(aicnd_pkg::REG_IDLE_THR, 32'h0000_0800);
    conv(16'h0400, 16'h0);
    repeat (6) @(posedge core_clk);
    #1;
    check("early", {31'h0, idle_stop[0]}, 32'h0);
    conv(16'h1000, 16'h0);
    repeat (4) @(posedge core_clk);
    conv(16'h0400, 16'h0);
    repeat (10) @(posedge core_clk);
    #1;
    check("restart", {31'h0, idle_stop[0]}, 32'h0);
    wait_stop(1'b1);
    rd(aicnd_pkg::REG_STATUS, d);
    check("status", d, 32'h1);
    conv(16'h1000, 16'h0);
    wait_stop(1'b0);
    wr(aicnd_pkg::REG_CH_CFG, 32'h2);
    conv(16'hF000, 16'h0);
    repeat (20) @(posedge core_clk);
    #1;
    check("joy big", {31'h0, idle_stop[0]}, 32'h0);
    conv(16'hFC00, 16'h0);
    wait_stop(1'b1);
    $display("idle test done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (50000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end

  // main sequence
  initial begin
    rst();
    t_regs();
    t_span();
    t_dead();
    t_trim();
    t_filt();
    t_fbus();
    t_idle();
    stop_test();
  end
endmodule
`default_nettype wire
